// ---- pcr_regs.svh ----
// Register indices, field positions, reset values and timing for the card configuration block.
// Assumes the includer uses byte address = four times the index.
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH
// Register indices
`define PCR_IDX_CTRL 8'h02
`define PCR_IDX_WAKE 8'h03
`define PCR_IDX_RDATA 8'h04
`define PCR_IDX_STAT 8'h05
`define PCR_IDX_CSN 8'h06
`define PCR_IDX_LSEL 8'h07
`define PCR_IDX_ACT 8'h30
`define PCR_IDX_RCHK 8'h31
// Field positions
`define PCR_CTRL_LDRST 0
`define PCR_CTRL_SLEEP 1
`define PCR_CTRL_CSNRST 2
`define PCR_STAT_RDY 0
`define PCR_ACT_EN 0
`define PCR_RCHK_PAT 0
`define PCR_RCHK_EN 1
// Reset values and fixed data
`define PCR_CSN_RST 8'h00
`define PCR_RBYTE_RST 8'h00
`define PCR_WAKE_ISOL 8'h00
`define PCR_PAT_ONE 16'h0055
`define PCR_PAT_ZERO 16'h00AA
// Bus responses
`define PCR_RESP_OKAY 2'h0
`define PCR_RESP_SLVERR 2'h2
// Timing: cycles to fetch one resource byte
`define PCR_RES_LAT 4
`endif

// ---- pcr_pkg.sv ----
// Types shared by the card configuration block.
// Assumes nothing of its surroundings.
package pcr_pkg;
	// Gray along sleep, isolation, config
	typedef enum logic [1:0] {
		PCR_SLEEP = 2'h0,
		PCR_ISOL = 2'h1,
		PCR_CONFIG = 2'h3
	} pcr_card_e;
endpackage

// ---- pcr_top.sv ----
// Card-level plug and play configuration registers behind an AXI4-Lite slave.
// Assumes one clock, synchronous reset, resource bytes supplied by an external store.
//
// The AXI4-Lite register port was chosen for this implementation.
`include "pcr_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module pcr_top
	import pcr_pkg::*;
#(
	parameter int NLD = 4,
	parameter int ADDR_W = 8,
	parameter int PTR_W = 8,
	parameter int RES_LAT = `PCR_RES_LAT,
	localparam int LW = (NLD > 1) ? $clog2(NLD) : 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [PTR_W-1:0] res_addr,
	input wire logic [7:0] res_byte,
	input wire logic io_rd_stb,
	input wire logic [LW-1:0] io_dev,
	output logic io_rsp_valid,
	output logic [15:0] io_rsp_data,
	output logic [NLD-1:0] dev_active,
	output logic [1:0] card_state
);

	localparam int CW = $clog2(RES_LAT + 1);

	typedef struct packed {
		pcr_card_e cst;
		logic [7:0] card_select_value;
		logic [LW-1:0] lsel;
		logic [NLD-1:0] act;
		logic [NLD-1:0] rchk;
		logic [NLD-1:0] rpat;
		logic [PTR_W-1:0] rptr;
		logic [CW-1:0] rcnt;
		logic rdy;
		logic [7:0] rbyte;
		logic aw_hold;
		logic [ADDR_W-1:0] awaddr;
		logic w_hold;
		logic [7:0] wdata;
		logic wlane;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic iov;
		logic [15:0] iod;
	} pcr_state_s;

	pcr_state_s s_q;
	pcr_state_s s_d;
	logic ar_go;
	logic wr_go;
	logic wr_do;
	logic [8:0] rdec;
	logic [8:0] wdec;
	logic io_chk;

	// Hit flag on top, index below; misaligned or unmapped gives no hit
	function automatic logic [8:0] f_decode(input logic [ADDR_W-1:0] a);
		logic [7:0] idx;
		logic hit;
		idx = 8'(a >> 2);
		hit = (a[1:0] == 2'h0) && ((a >> 2) == ADDR_W'(idx));
		case (idx)
			`PCR_IDX_CTRL, `PCR_IDX_WAKE, `PCR_IDX_RDATA, `PCR_IDX_STAT,
			`PCR_IDX_CSN, `PCR_IDX_LSEL, `PCR_IDX_ACT, `PCR_IDX_RCHK: begin
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return {hit, idx};
	endfunction

	// Unit index guard, since NLD need not be a power of two
	function automatic logic f_unit_ok(input logic [LW-1:0] u);
		return int'(u) < NLD;
	endfunction

	assign ar_go = s_axi_arvalid && s_q.arready;
	assign rdec = f_decode(s_axi_araddr);
	assign wr_go = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
	assign wdec = f_decode(s_q.awaddr);
	assign wr_do = wr_go && wdec[8] && s_q.wlane;
	assign io_chk = io_rd_stb && f_unit_ok(io_dev);

	always_comb begin
		s_d = s_q;
		s_d.iov = 1'b0;

		// Resource fetch: byte taken on the last count, address held steady meanwhile
		if (s_q.rcnt != '0) begin
			s_d.rcnt = s_q.rcnt - CW'(1);
			if (s_q.rcnt == CW'(1)) begin
				s_d.rdy = 1'b1;
				s_d.rbyte = res_byte;
			end
		end

		// Read channel
		if (ar_go) begin
			s_d.arready = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rresp = rdec[8] ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
			s_d.rdata = '0;
			if (rdec[8]) begin
				case (rdec[7:0])
					`PCR_IDX_RDATA: begin
						s_d.rdata[7:0] = s_q.rbyte;
						// Read without ready returns stale byte and keeps the pointer
						if (s_q.rdy) begin
							s_d.rptr = s_q.rptr + PTR_W'(1);
							s_d.rdy = 1'b0;
							s_d.rcnt = CW'(RES_LAT);
						end
					end
					`PCR_IDX_STAT: begin
						s_d.rdata[`PCR_STAT_RDY] = s_q.rdy;
					end
					`PCR_IDX_CSN: begin
						s_d.rdata[7:0] = s_q.card_select_value;
					end
					`PCR_IDX_LSEL: begin
						s_d.rdata[LW-1:0] = s_q.lsel;
					end
					`PCR_IDX_ACT: begin
						if (f_unit_ok(s_q.lsel)) begin
							s_d.rdata[`PCR_ACT_EN] = s_q.act[s_q.lsel];
						end
					end
					`PCR_IDX_RCHK: begin
						if (f_unit_ok(s_q.lsel)) begin
							s_d.rdata[`PCR_RCHK_EN] = s_q.rchk[s_q.lsel];
							s_d.rdata[`PCR_RCHK_PAT] = s_q.rpat[s_q.lsel];
						end
					end
					default: begin
						// Control and wake read as zero
						s_d.rdata = '0;
					end
				endcase
			end
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
			s_d.arready = 1'b1;
		end

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && s_q.awready) begin
			s_d.awready = 1'b0;
			s_d.aw_hold = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.wready = 1'b0;
			s_d.w_hold = 1'b1;
			s_d.wdata = s_axi_wdata[7:0];
			s_d.wlane = s_axi_wstrb[0];
		end
		if (wr_go) begin
			s_d.aw_hold = 1'b0;
			s_d.w_hold = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = wdec[8] ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
		end else if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
			s_d.awready = 1'b1;
			s_d.wready = 1'b1;
		end

		// Write effects come last so a wake beats a same-cycle pop
		if (wr_do) begin
			case (wdec[7:0])
				`PCR_IDX_CTRL: begin
					// Commands act once and store nothing
					if (s_q.wdata[`PCR_CTRL_CSNRST]) begin
						s_d.card_select_value = `PCR_CSN_RST;
					end
					if (s_q.wdata[`PCR_CTRL_LDRST]) begin
						s_d.act = '0;
						s_d.rchk = '0;
						s_d.rpat = '0;
						s_d.lsel = '0;
					end
					if (s_q.wdata[`PCR_CTRL_SLEEP]) begin
						s_d.cst = PCR_SLEEP;
					end
				end
				`PCR_IDX_WAKE: begin
					s_d.rptr = '0;
					s_d.rdy = 1'b0;
					s_d.rcnt = CW'(RES_LAT);
					if (s_q.cst == PCR_SLEEP && s_q.wdata == s_q.card_select_value) begin
						s_d.cst = (s_q.wdata == `PCR_WAKE_ISOL) ? PCR_ISOL : PCR_CONFIG;
					end else if (s_q.cst != PCR_SLEEP && s_q.wdata != s_q.card_select_value) begin
						s_d.cst = PCR_SLEEP;
					end
				end
				`PCR_IDX_CSN: begin
					s_d.card_select_value = s_q.wdata;
				end
				`PCR_IDX_LSEL: begin
					// Out-of-range selection ignored; one unit keeps zero
					if (NLD > 1 && int'(s_q.wdata) < NLD) begin
						s_d.lsel = LW'(s_q.wdata);
					end
				end
				`PCR_IDX_ACT: begin
					if (f_unit_ok(s_q.lsel)) begin
						s_d.act[s_q.lsel] = s_q.wdata[`PCR_ACT_EN];
					end
				end
				`PCR_IDX_RCHK: begin
					if (f_unit_ok(s_q.lsel)) begin
						s_d.rchk[s_q.lsel] = s_q.wdata[`PCR_RCHK_EN];
						s_d.rpat[s_q.lsel] = s_q.wdata[`PCR_RCHK_PAT];
					end
				end
				default: begin
					// Resource data and status are read-only
					s_d.cst = s_d.cst;
				end
			endcase
		end

		// Active units answer through their own logic, not here
		if (io_chk && !s_q.act[io_dev] && s_q.rchk[io_dev]) begin
			s_d.iov = 1'b1;
			s_d.iod = s_q.rpat[io_dev] ? `PCR_PAT_ONE : `PCR_PAT_ZERO;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.cst <= PCR_SLEEP;
			s_q.card_select_value <= `PCR_CSN_RST;
			s_q.rbyte <= `PCR_RBYTE_RST;
			s_q.rcnt <= CW'(RES_LAT);
			s_q.awready <= 1'b1;
			s_q.wready <= 1'b1;
			s_q.arready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rvalid = s_q.rvalid;
	assign res_addr = s_q.rptr;
	assign io_rsp_valid = s_q.iov;
	assign io_rsp_data = s_q.iod;
	assign dev_active = s_q.act;
	assign card_state = s_q.cst;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_csn_clear;
		wr_do && wdec[7:0] == `PCR_IDX_CTRL && s_q.wdata[`PCR_CTRL_CSNRST]
			|=> s_q.card_select_value == 8'h00 && s_q.bvalid;
	endproperty
	a_csn_clear: assert property (p_csn_clear) else $error("select number not cleared");

	property p_wake;
		wr_do && wdec[7:0] == `PCR_IDX_WAKE && s_q.cst == PCR_SLEEP && s_q.wdata == s_q.card_select_value
			|=> s_q.cst == (($past(s_q.wdata) == 8'h00) ? PCR_ISOL : PCR_CONFIG);
	endproperty
	a_wake: assert property (p_wake) else $error("wake state wrong");

	property p_rewind;
		wr_do && wdec[7:0] == `PCR_IDX_WAKE
			|=> s_q.rptr == '0 && !s_q.rdy && s_q.rcnt == CW'(RES_LAT) ##1 (RES_LAT == 1 || !s_q.rdy);
	endproperty
	a_rewind: assert property (p_rewind) else $error("pointer not rewound");

	property p_wake_rd;
		ar_go && rdec == {1'b1, `PCR_IDX_WAKE} |=> s_q.rvalid && s_q.rdata == 32'h0;
	endproperty
	a_wake_rd: assert property (p_wake_rd) else $error("wake read not zero");

	property p_pop;
		ar_go && rdec == {1'b1, `PCR_IDX_RDATA} && s_q.rdy && !(wr_do && wdec[7:0] == `PCR_IDX_WAKE)
			|=> s_q.rptr == PTR_W'($past(s_q.rptr) + 1'b1) && !s_q.rdy;
	endproperty
	a_pop: assert property (p_pop) else $error("resource pop wrong");

	property p_stat;
		ar_go && rdec == {1'b1, `PCR_IDX_STAT} |=> s_q.rdata == {31'h0, $past(s_q.rdy)};
	endproperty
	a_stat: assert property (p_stat) else $error("status read wrong");

	property p_lsel;
		int'(s_q.lsel) < NLD;
	endproperty
	a_lsel: assert property (p_lsel) else $error("unit select out of range");

	property p_act_wr;
		wr_do && wdec[7:0] == `PCR_IDX_ACT && f_unit_ok(s_q.lsel)
			|=> s_q.act[$past(s_q.lsel)] == $past(s_q.wdata[0]);
	endproperty
	a_act_wr: assert property (p_act_wr) else $error("activate not stored");

	property p_rsvd;
		ar_go && rdec[8] && (rdec[7:0] == `PCR_IDX_ACT || rdec[7:0] == `PCR_IDX_RCHK)
			|=> s_q.rdata[31:2] == 30'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

	property p_pattern;
		io_chk && !s_q.act[io_dev] && s_q.rchk[io_dev]
			|=> s_q.iov && s_q.iod == ($past(s_q.rpat[io_dev]) ? 16'h0055 : 16'h00AA);
	endproperty
	a_pattern: assert property (p_pattern) else $error("range check pattern wrong");

	property p_quiet;
		!(io_chk && !s_q.act[io_dev] && s_q.rchk[io_dev]) |=> !s_q.iov;
	endproperty
	a_quiet: assert property (p_quiet) else $error("unexpected range answer");

	c_config: cover property (wr_do && wdec[7:0] == `PCR_IDX_WAKE ##1 s_q.cst == PCR_CONFIG);
	c_pop: cover property (ar_go && rdec == {1'b1, `PCR_IDX_RDATA} && s_q.rdy);
	c_pat55: cover property (s_q.iov && s_q.iod == 16'h0055);
	c_csn0: cover property (wr_do && wdec[7:0] == `PCR_IDX_CTRL && s_q.card_select_value != 8'h00);

endmodule

`default_nettype wire

// ---- pcr_res_store.sv ----
// Resource byte store model for the card configuration bench.
// Assumes the block samples res_byte LAT edges after res_addr moves.
`timescale 1ns/10ps
`default_nettype none
module pcr_res_store #(
	parameter int LAT = 3
) (
	input wire logic aclk,
	input wire logic [7:0] res_addr,
	output logic [7:0] res_byte
);
	logic [7:0] last_q = 8'h00;
	int age_q = 0;
	logic [7:0] good;
	always_ff @(posedge aclk) begin
		last_q <= res_addr;
		age_q <= (res_addr !== last_q) ? 1 : age_q + 1;
	end
	// Unsettled byte is inverted so an early sample fails
	always_comb begin
		good = {res_addr[3:0], res_addr[7:4]} ^ 8'hC3;
		res_byte = (LAT == 1 || (res_addr === last_q && age_q >= LAT - 1)) ? good : ~good;
	end
endmodule
`default_nettype wire

// ---- test_pnp_card_config_registers.sv ----
// Bench for the card configuration registers: AXI4-Lite tasks and range check pulses.
// Assumes the resource store model and the block's own assertions.
`timescale 1ns/10ps
`default_nettype none
module test_pnp_card_config_registers;
	localparam int LAT = 3;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, res_addr, res_byte;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF, dev_active;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, io_rsp_valid;
	logic [1:0] s_axi_bresp, s_axi_rresp, card_state, io_dev = 0;
	logic io_rd_stb = 0;
	logic [15:0] io_rsp_data;
	int n_fail = 0;
	int n_tests = 0;
	logic [7:0] ck_w [4] = '{8'h01, 8'hFE, 8'hFF, 8'hFE};
	logic [7:0] ck_r [4] = '{8'h01, 8'h02, 8'h03, 8'h02};
	logic [15:0] pat [4] = '{16'h0000, 16'h0000, 16'h0055, 16'h00AA};

	pcr_top #(.NLD(4), .ADDR_W(8), .PTR_W(8), .RES_LAT(LAT)) DUT (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.res_addr, .res_byte, .io_rd_stb, .io_dev, .io_rsp_valid, .io_rsp_data, .dev_active, .card_state
	);
	pcr_res_store #(.LAT(LAT)) u_store (.aclk, .res_addr, .res_byte);

	always #2 aclk = ~aclk;

	task automatic give_verdict();
		if (n_fail == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	// Ready flags are registered, so sampling at the falling edge sees the rising-edge value
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw, w, b;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= {a[5:0], 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
		logic ar, v;
		@(posedge aclk);
		s_axi_araddr <= {a[5:0], 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ar = s_axi_arvalid & s_axi_arready;
			v = s_axi_rvalid;
			q = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
		end while (!v);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		logic [31:0] q;
		logic [1:0] r;
		rd(a, q, r);
		chk(q, {24'h0, e});
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic pop(input logic [7:0] p);
		logic [31:0] q;
		logic [1:0] r;
		q = 0;
		while (q[0] !== 1'b1) rd(8'h05, q, r);
		rc(8'h04, {p[3:0], p[7:4]} ^ 8'hC3, 2'h0);
	endtask
	task automatic io(input logic [1:0] d, input logic ev, input logic [15:0] ed);
		@(posedge aclk);
		io_rd_stb <= 1'b1;
		io_dev <= d;
		@(posedge aclk);
		io_rd_stb <= 1'b0;
		#1;
		chk({31'h0, io_rsp_valid}, {31'h0, ev});
		if (ev) chk({16'h0, io_rsp_data}, {16'h0, ed});
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc(8'h06, 8'h00, 2'h0);
		wr(8'h06, 8'h05, 2'h0);
		rc(8'h06, 8'h05, 2'h0);
		wr(8'h03, 8'h07, 2'h0);
		chk({30'h0, card_state}, 32'h0);
		wr(8'h03, 8'h05, 2'h0);
		chk({30'h0, card_state}, 32'h3);
		wr(8'h03, 8'h00, 2'h0);
		chk({30'h0, card_state}, 32'h0);
		wr(8'h02, 8'h04, 2'h0);
		rc(8'h06, 8'h00, 2'h0);
		rc(8'h02, 8'h00, 2'h0);
		wr(8'h03, 8'h00, 2'h0);
		chk({30'h0, card_state}, 32'h1);
		rc(8'h03, 8'h00, 2'h0);
		pop(8'h00);
		pop(8'h01);
		// Writes to read-only places must leave the pointer alone
		wr(8'h04, 8'h00, 2'h0);
		wr(8'h05, 8'h00, 2'h0);
		pop(8'h02);
		wr(8'h03, 8'h09, 2'h0);
		pop(8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(8'h07, 8'(k), 2'h0);
			wr(8'h30, (k == 1) ? 8'hFF : 8'hFE, 2'h0);
			wr(8'h31, ck_w[k], 2'h0);
		end
		chk({28'h0, dev_active}, 32'h2);
		for (int k = 0; k < 4; k++) begin
			wr(8'h07, 8'(k), 2'h0);
			rc(8'h30, (k == 1) ? 8'h01 : 8'h00, 2'h0);
			rc(8'h31, ck_r[k], 2'h0);
		end
		rc(8'h07, 8'h03, 2'h0);
		for (int k = 0; k < 4; k++) begin
			io(2'(k), (k >= 2), pat[k]);
		end
		wr(8'h07, 8'h01, 2'h0);
		wr(8'h30, 8'h00, 2'h0);
		chk({28'h0, dev_active}, 32'h0);
		io(2'h1, 1'b1, 16'h00AA);
		io(2'h2, 1'b1, 16'h0055);
		// Unmapped index answers with an error and no effect
		rc(8'h3F, 8'h00, 2'h2);
		wr(8'h3F, 8'h01, 2'h2);
		// Selection beyond the last unit is ignored
		wr(8'h07, 8'h04, 2'h0);
		rc(8'h07, 8'h01, 2'h0);
		// Byte lane 0 off: accepted but stores nothing
		s_axi_wstrb <= 4'h0;
		wr(8'h06, 8'hAB, 2'h0);
		s_axi_wstrb <= 4'hF;
		rc(8'h06, 8'h00, 2'h0);
		wr(8'h03, 8'h00, 2'h0);
		chk({30'h0, card_state}, 32'h1);
		wr(8'h02, 8'h02, 2'h0);
		chk({30'h0, card_state}, 32'h0);
		wr(8'h02, 8'h01, 2'h0);
		rc(8'h02, 8'h00, 2'h0);
		rc(8'h07, 8'h00, 2'h0);
		wr(8'h07, 8'h02, 2'h0);
		rc(8'h31, 8'h00, 2'h0);
		io(2'h2, 1'b0, 16'h0000);
		give_verdict();
	end

	// Whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		give_verdict();
	end
endmodule
`default_nettype wire
